// File: data_map_defs.vh
`ifndef DATA_MAP_DEFS_VH
`define DATA_MAP_DEFS_VH
// ----------------------------------------------------------------------
// Register offsets in the special function register space.
// ----------------------------------------------------------------------
`define SFR_STACK_POINTER  8'h81
`define SFR_POINTER0_LOW   8'h82
`define SFR_POINTER0_HIGH  8'h83
`define SFR_POINTER1_LOW   8'h84
`define SFR_POINTER1_HIGH  8'h85
`define SFR_RAM_PAGE_CTRL  8'h86
`define SFR_STATUS_WORD    8'hd0
`define REGISTER_PAGE_SELECT_SELECT    8'hec
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_STACK_POINTER  8'h07
`define RST_POINTER        8'h00
`define RST_RAM_PAGE_CTRL  8'hf0
`define RST_STATUS_WORD    8'h00
`define RST_PAGE_SELECT    8'h00
// ----------------------------------------------------------------------
// Field positions and address ranges.
// ----------------------------------------------------------------------
`define BANK_SELECT_LO     3
`define BANK_SELECT_HI     4
`define EXPANDED_DATA_RAM_BASE          16'hf000
`define EXPANDED_DATA_RAM_LAST          16'hf1ff
`define INTERNAL_DATA_RAM_UPPER_BIT     7
`endif

// File: data_ram.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Single-port byte memory in flip-flops, read data registered.
// ----------------------------------------------------------------------
module data_ram #(
  parameter DEPTH  = 256,
  parameter ADDR_W = 8
) (
  // Clock.
  input  wire              clk_sys,
  // Access port.
  input  wire [ADDR_W-1:0] addr,
  input  wire              wr_en,
  input  wire [7:0]        wr_data,
  output reg  [7:0]        rd_data_ff
);

  reg [7:0] mem_ff [0:DEPTH-1];

  // Storage has no reset; contents are undefined until written.
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem_ff[addr] <= wr_data;
    end
    rd_data_ff <= mem_ff[addr];
  end

endmodule // data_ram
`default_nettype wire

// File: data_memory_address_map.v
`timescale 1ns/1ps
`default_nettype none
`include "data_map_defs.vh"

module data_memory_address_map #(
  parameter INTERNAL_DATA_RAM_DEPTH = 256,
  parameter EXPANDED_DATA_RAM_DEPTH = 512
) (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        rst,
  // Core access request, one access per strobe.
  input  wire        acc_valid,
  input  wire [1:0]  acc_mode,
  input  wire        acc_write,
  input  wire [15:0] acc_addr,
  input  wire [7:0]  acc_wdata,
  // Core read answer.
  output reg         rd_valid_ff,
  output reg  [7:0]  rd_data_ff,
  // Peripheral register space beyond the registers held here.
  output reg         sfr_ext_sel_ff,
  output reg         sfr_ext_wr_ff,
  output reg  [7:0]  sfr_ext_addr_ff,
  output reg  [7:0]  sfr_ext_wdata_ff,
  input  wire [7:0]  sfr_ext_rdata,
  // Register state seen by the rest of the core.
  output reg  [7:0]  stack_pointer_ff,
  output reg  [15:0] data_pointer_pair0_ff,
  output reg  [15:0] data_pointer_pair1_ff,
  output reg  [7:0]  ram_page_control_ff,
  output reg  [7:0]  program_status_word_ff,
  output reg  [7:0]  register_page_select_ff
);

  // --------------------------------------------------------------------
  // Access modes.
  // --------------------------------------------------------------------
  localparam [1:0] MODE_DIRECT   = 2'd0;
  localparam [1:0] MODE_INDIRECT = 2'd1;
  localparam [1:0] MODE_REGISTER = 2'd2;
  localparam [1:0] MODE_EXTERNAL = 2'd3;

  // Read source of the pending answer, one-hot.
  localparam [3:0] SRC_INTERNAL_DATA_RAM = 4'b0001;
  localparam [3:0] SRC_EXPANDED_DATA_RAM = 4'b0010;
  localparam [3:0] SRC_SFR  = 4'b0100;
  localparam [3:0] SRC_NONE = 4'b1000;

  // Bank base is eight times the two-bit select.
  function [7:0] bank_base;
    input [7:0] program_status_word;
    begin
      bank_base = {3'b000, program_status_word[`BANK_SELECT_HI], program_status_word[`BANK_SELECT_LO], 3'b000};
    end
  endfunction

  reg  [7:0]  internal_data_ram_addr;
  reg         internal_data_ram_wr;
  reg  [8:0]  expanded_data_ram_addr;
  reg         expanded_data_ram_wr;
  reg         sfr_hit;
  reg  [3:0]  nxt_src;
  reg  [3:0]  src_ff;
  reg  [15:0] ext_addr;
  reg  [7:0]  sfr_local;
  reg         sfr_local_hit;
  reg  [7:0]  sfr_local_ff;
  reg         sfr_local_hit_ff;
  wire [7:0]  internal_data_ram_rdata;
  wire [7:0]  expanded_data_ram_rdata;

  // --------------------------------------------------------------------
  // Address decode.
  // --------------------------------------------------------------------
  // External pointer address: short form uses page control as high byte.
  always @* begin
    ext_addr = acc_addr;
    if (acc_addr[15:8] == 8'h00) begin
      ext_addr = {ram_page_control_ff, acc_addr[7:0]};
    end
  end

  // Steer each access to at most one target; external accesses outside the window reach none.
  always @* begin
    internal_data_ram_addr = acc_addr[7:0];
    internal_data_ram_wr   = 1'b0;
    expanded_data_ram_addr = ext_addr[8:0];
    expanded_data_ram_wr   = 1'b0;
    sfr_hit   = 1'b0;
    nxt_src   = SRC_NONE;
    if (acc_valid) begin
      case (acc_mode)
        MODE_DIRECT: begin
          if (acc_addr[`INTERNAL_DATA_RAM_UPPER_BIT]) begin
            sfr_hit = 1'b1;
            nxt_src = SRC_SFR;
          end else begin
            internal_data_ram_wr = acc_write;
            nxt_src = SRC_INTERNAL_DATA_RAM;
          end
        end
        MODE_INDIRECT: begin
          internal_data_ram_wr = acc_write;
          nxt_src = SRC_INTERNAL_DATA_RAM;
        end
        MODE_REGISTER: begin
          internal_data_ram_addr = bank_base(program_status_word_ff) | {5'b00000, acc_addr[2:0]};
          internal_data_ram_wr   = acc_write;
          nxt_src   = SRC_INTERNAL_DATA_RAM;
        end
        MODE_EXTERNAL: begin
          // Outside the window writes drop and reads get no answer at all.
          if (ext_addr >= `EXPANDED_DATA_RAM_BASE && ext_addr <= `EXPANDED_DATA_RAM_LAST) begin
            expanded_data_ram_wr = acc_write;
            nxt_src = SRC_EXPANDED_DATA_RAM;
          end
        end
        default: nxt_src = SRC_NONE;
      endcase
    end
  end

  // Local register read mux.
  always @* begin
    sfr_local_hit = 1'b1;
    case (acc_addr[7:0])
      `SFR_STACK_POINTER: sfr_local = stack_pointer_ff;
      `SFR_POINTER0_LOW:  sfr_local = data_pointer_pair0_ff[7:0];
      `SFR_POINTER0_HIGH: sfr_local = data_pointer_pair0_ff[15:8];
      `SFR_POINTER1_LOW:  sfr_local = data_pointer_pair1_ff[7:0];
      `SFR_POINTER1_HIGH: sfr_local = data_pointer_pair1_ff[15:8];
      `SFR_RAM_PAGE_CTRL: sfr_local = ram_page_control_ff;
      `SFR_STATUS_WORD:   sfr_local = program_status_word_ff;
      `REGISTER_PAGE_SELECT_SELECT:   sfr_local = register_page_select_ff;
      default: begin
        sfr_local     = 8'h00;
        sfr_local_hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Memories.
  // --------------------------------------------------------------------
  data_ram #(.DEPTH(INTERNAL_DATA_RAM_DEPTH), .ADDR_W(8)) u_internal_data_ram (
    .clk_sys    (clk_sys),
    .addr       (internal_data_ram_addr),
    .wr_en      (internal_data_ram_wr),
    .wr_data    (acc_wdata),
    .rd_data_ff (internal_data_ram_rdata)
  );

  // One 512-byte page; upper address bits are decoded above.
  data_ram #(.DEPTH(EXPANDED_DATA_RAM_DEPTH), .ADDR_W(9)) u_expanded_data_ram (
    .clk_sys    (clk_sys),
    .addr       (expanded_data_ram_addr),
    .wr_en      (expanded_data_ram_wr),
    .wr_data    (acc_wdata),
    .rd_data_ff (expanded_data_ram_rdata)
  );

  // --------------------------------------------------------------------
  // Special registers held in this block.
  // --------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_pointer_ff        <= `RST_STACK_POINTER;
      data_pointer_pair0_ff   <= {`RST_POINTER, `RST_POINTER};
      data_pointer_pair1_ff   <= {`RST_POINTER, `RST_POINTER};
      ram_page_control_ff     <= `RST_RAM_PAGE_CTRL;
      program_status_word_ff  <= `RST_STATUS_WORD;
      register_page_select_ff <= `RST_PAGE_SELECT;
    end else if (sfr_hit && acc_write) begin
      case (acc_addr[7:0])
        `SFR_STACK_POINTER: stack_pointer_ff <= acc_wdata;
        `SFR_POINTER0_LOW:  data_pointer_pair0_ff[7:0]  <= acc_wdata;
        `SFR_POINTER0_HIGH: data_pointer_pair0_ff[15:8] <= acc_wdata;
        `SFR_POINTER1_LOW:  data_pointer_pair1_ff[7:0]  <= acc_wdata;
        `SFR_POINTER1_HIGH: data_pointer_pair1_ff[15:8] <= acc_wdata;
        `SFR_RAM_PAGE_CTRL: ram_page_control_ff     <= acc_wdata;
        `SFR_STATUS_WORD:   program_status_word_ff  <= acc_wdata;
        `REGISTER_PAGE_SELECT_SELECT:   register_page_select_ff <= acc_wdata;
        default:            stack_pointer_ff <= stack_pointer_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Outward register port and answer pipeline.
  // --------------------------------------------------------------------
  // Addresses not held here pass outward; peripherals see the page output.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_ext_sel_ff   <= 1'b0;
      sfr_ext_wr_ff    <= 1'b0;
      sfr_ext_addr_ff  <= 8'h00;
      sfr_ext_wdata_ff <= 8'h00;
      src_ff           <= SRC_NONE;
      sfr_local_ff     <= 8'h00;
      sfr_local_hit_ff <= 1'b0;
      rd_valid_ff      <= 1'b0;
      rd_data_ff       <= 8'h00;
    end else begin
      sfr_ext_sel_ff   <= sfr_hit && !sfr_local_hit;
      sfr_ext_wr_ff    <= sfr_hit && !sfr_local_hit && acc_write;
      sfr_ext_addr_ff  <= acc_addr[7:0];
      sfr_ext_wdata_ff <= acc_wdata;
      src_ff           <= (acc_valid && !acc_write) ? nxt_src : SRC_NONE;
      sfr_local_ff     <= sfr_local;
      sfr_local_hit_ff <= sfr_local_hit;
      rd_valid_ff      <= (src_ff != SRC_NONE) || (acc_valid && !acc_write && nxt_src == SRC_NONE
                          && 1'b0);
      case (src_ff)
        SRC_INTERNAL_DATA_RAM: rd_data_ff <= internal_data_ram_rdata;
        SRC_EXPANDED_DATA_RAM: rd_data_ff <= expanded_data_ram_rdata;
        SRC_SFR:  rd_data_ff <= sfr_local_hit_ff ? sfr_local_ff : sfr_ext_rdata;
        SRC_NONE: rd_data_ff <= 8'h00;
        default:  rd_data_ff <= 8'h00;
      endcase
    end
  end

endmodule // data_memory_address_map
`default_nettype wire

// File: mem_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the data address map.
// ------------------------------------------------------------
module mem_map_asserts (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst,
  // Core request side.
  input wire logic        acc_valid,
  input wire logic [1:0]  acc_mode,
  input wire logic        acc_write,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0]  acc_wdata,
  // Answers, outward port and register state.
  input wire logic        rd_valid_ff,
  input wire logic        sfr_ext_sel_ff,
  input wire logic        sfr_ext_wr_ff,
  input wire logic [7:0]  sfr_ext_addr_ff,
  input wire logic [15:0] data_pointer_pair0_ff,
  input wire logic [7:0]  ram_page_control_ff,
  input wire logic [7:0]  program_status_word_ff,
  input wire logic [7:0]  register_page_select_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A direct write, the only way the held registers may change.
  wire dir_wr = acc_valid && acc_write && acc_mode == 2'h0;
  chk_read_answer: assert property (acc_valid && !acc_write && acc_mode != 2'h3 |-> ##2 rd_valid_ff)
    else $error("internal read not answered");
  chk_answer_cause: assert property (rd_valid_ff |-> $past(acc_valid, 2) && !$past(acc_write, 2))
    else $error("answer without a read");
  chk_status_write: assert property (dir_wr && acc_addr[7:0] == 8'hd0 |=> program_status_word_ff == $past(acc_wdata))
    else $error("status word not written");
  chk_page_ctrl: assert property (dir_wr && acc_addr[7:0] == 8'h86 |=> ram_page_control_ff == $past(acc_wdata))
    else $error("page control not written");
  chk_pointer_low: assert property (dir_wr && acc_addr[7:0] == 8'h82 |=> data_pointer_pair0_ff[7:0] == $past(acc_wdata))
    else $error("pointer low byte not written");
  chk_sfr_outward: assert property (dir_wr && acc_addr[7:0] == 8'hd2 |=> sfr_ext_sel_ff && sfr_ext_wr_ff && sfr_ext_addr_ff == 8'hd2)
    else $error("direct upper access not sent outward");
  chk_indirect_inward: assert property (acc_valid && acc_mode == 2'h1 |=> !sfr_ext_sel_ff)
    else $error("indirect access sent outward");
  chk_expanded_data_ram_refuse: assert property (acc_valid && !acc_write && acc_mode == 2'h3 && acc_addr[15:8] != 8'h00 && acc_addr[15:9] != 7'h78 |-> ##2 !rd_valid_ff)
    else $error("out of range external read answered");
  chk_page_hold: assert property (!(dir_wr && acc_addr[7:0] == 8'hec) |=> $stable(register_page_select_ff))
    else $error("page select changed without a write");
endmodule // mem_map_asserts
bind data_memory_address_map mem_map_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .acc_valid(acc_valid), .acc_mode(acc_mode), .acc_write(acc_write), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .rd_valid_ff(rd_valid_ff), .sfr_ext_sel_ff(sfr_ext_sel_ff),
  .sfr_ext_wr_ff(sfr_ext_wr_ff), .sfr_ext_addr_ff(sfr_ext_addr_ff),
  .data_pointer_pair0_ff(data_pointer_pair0_ff), .ram_page_control_ff(ram_page_control_ff),
  .program_status_word_ff(program_status_word_ff),
  .register_page_select_ff(register_page_select_ff));
`default_nettype wire

// File: sfr_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Peripheral register space beyond the map, paged.
// ------------------------------------------------------------
module sfr_periph_model (
  // Clock.
  input wire logic       clk_sys,
  // Outward register port.
  input wire logic       sel,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] page,
  output logic [7:0]     rdata
);
  logic [7:0]  regs [0:2047];
  logic [10:0] last_ff;
  logic        hold_ff;
  // Each page owns its own copy of every shared address.
  always @(posedge clk_sys) begin
    hold_ff <= sel;
    if (sel) last_ff <= {page, addr};
    if (sel && wr) regs[{page, addr}] <= wdata;
  end
  // Data holds one cycle past the select, then inverts so a late sample shows up.
  assign rdata = sel ? regs[{page, addr}] : (hold_ff ? regs[last_ff] : ~regs[last_ff]);
endmodule // sfr_periph_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        acc_valid = 1'b0;
  logic [1:0]  acc_mode = 2'h0;
  logic        acc_write = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0]  acc_wdata = 8'h00;
  wire         rd_valid_ff, sfr_ext_sel_ff, sfr_ext_wr_ff;
  wire  [7:0]  rd_data_ff, sfr_ext_addr_ff, sfr_ext_wdata_ff, sfr_ext_rdata, stack_pointer_ff;
  wire  [7:0]  ram_page_control_ff, program_status_word_ff, register_page_select_ff;
  wire  [15:0] data_pointer_pair0_ff, data_pointer_pair1_ff;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          i;
  data_memory_address_map uut (.clk_sys(clk_sys), .rst(rst), .acc_valid(acc_valid),
    .acc_mode(acc_mode), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff), .sfr_ext_sel_ff(sfr_ext_sel_ff),
    .sfr_ext_wr_ff(sfr_ext_wr_ff), .sfr_ext_addr_ff(sfr_ext_addr_ff),
    .sfr_ext_wdata_ff(sfr_ext_wdata_ff), .sfr_ext_rdata(sfr_ext_rdata),
    .stack_pointer_ff(stack_pointer_ff), .data_pointer_pair0_ff(data_pointer_pair0_ff),
    .data_pointer_pair1_ff(data_pointer_pair1_ff), .ram_page_control_ff(ram_page_control_ff),
    .program_status_word_ff(program_status_word_ff),
    .register_page_select_ff(register_page_select_ff));
  sfr_periph_model far_end (.clk_sys(clk_sys), .sel(sfr_ext_sel_ff), .wr(sfr_ext_wr_ff),
    .addr(sfr_ext_addr_ff), .wdata(sfr_ext_wdata_ff), .page(register_page_select_ff[2:0]),
    .rdata(sfr_ext_rdata));
  // ------------------------------------------------------------
  // Clock, hang limit and shared tasks.
  // ------------------------------------------------------------
  always #10 clk_sys = ~clk_sys;
  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request, held for exactly the taking edge.
  task automatic req(input logic [1:0] m, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_mode <= m;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
  endtask
  // A read; the answer window is bounded, a refused read must stay silent.
  task automatic rd(input logic [1:0] m, input logic [15:0] a, input logic [7:0] exp, input logic ans);
    logic got;
    got = 1'b0;
    req(m, 1'b0, a, 8'h00);
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      if (rd_valid_ff === 1'b1 && !got) begin
        got = 1'b1;
        check("read data", {8'h00, rd_data_ff}, {8'h00, exp});
      end
    end
    check("answer", {15'h0000, got}, {15'h0000, ans});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    check("sp and page ctrl", {stack_pointer_ff, ram_page_control_ff}, 16'h07f0);
    check("page sel and psw", {register_page_select_ff, program_status_word_ff}, 16'h0000);
    check("pointer0", data_pointer_pair0_ff, 16'h0000);
    check("pointer1", data_pointer_pair1_ff, 16'h0000);
    rst <= 1'b0;
    // Lower bytes both ways; upper address split between RAM and peripherals.
    req(2'h0, 1'b1, 16'h0030, 8'h3c);
    rd(2'h1, 16'h0030, 8'h3c, 1'b1);
    req(2'h1, 1'b1, 16'h00d2, 8'ha5);
    req(2'h0, 1'b1, 16'h00d2, 8'h5a);
    rd(2'h1, 16'h00d2, 8'ha5, 1'b1);
    rd(2'h0, 16'h00d2, 8'h5a, 1'b1);
    req(2'h0, 1'b1, 16'h00ec, 8'h01);
    req(2'h0, 1'b1, 16'h00d2, 8'h77);
    rd(2'h0, 16'h00d2, 8'h77, 1'b1);
    req(2'h0, 1'b1, 16'h00ec, 8'h00);
    rd(2'h0, 16'h00d2, 8'h5a, 1'b1);
    // Same register number in every bank must land in a different byte.
    for (i = 0; i < 4; i++) begin
      req(2'h0, 1'b1, 16'h00d0, {3'h0, i[1:0], 3'h0});
      req(2'h2, 1'b1, 16'h0003, {6'h10, i[1:0]});
      rd(2'h2, 16'h0003, {6'h10, i[1:0]}, 1'b1);
    end
    for (i = 0; i < 4; i++) rd(2'h0, {11'h000, i[1:0], 3'h3}, {6'h10, i[1:0]}, 1'b1);
    // Expanded RAM ends, short pointer form and a refused address.
    req(2'h3, 1'b1, 16'hf000, 8'h11);
    req(2'h3, 1'b1, 16'hf1ff, 8'h22);
    rd(2'h3, 16'hf000, 8'h11, 1'b1);
    req(2'h0, 1'b1, 16'h0086, 8'hf1);
    rd(2'h3, 16'h00ff, 8'h22, 1'b1);
    rd(2'h3, 16'hf200, 8'h00, 1'b0);
    // Pointer bytes written one by one.
    for (i = 2; i < 6; i++) req(2'h0, 1'b1, {13'h0010, i[2:0]}, {5'h14, i[2:0]});
    #1;
    check("pointer0", data_pointer_pair0_ff, 16'ha3a2);
    check("pointer1", data_pointer_pair1_ff, 16'ha5a4);
    // Registers held in the map must also read back over the direct path.
    rd(2'h0, 16'h0083, 8'ha3, 1'b1);
    rd(2'h0, 16'h0086, 8'hf1, 1'b1);
    req(2'h0, 1'b1, 16'h0081, 8'h5c);
    rd(2'h0, 16'h0081, 8'h5c, 1'b1);
    check("stack pointer", {8'h00, stack_pointer_ff}, 16'h005c);
    end_sim;
  end
endmodule // tb
`default_nettype wire
